// file: dgc_pkg.sv
// package: constants shared by both ends of the gain-correcting converter link
// Behaviour
// - separate gain word per converter channel
// - seven bits: sign plus six-bit magnitude
// - sign zero scales by one minus m/4096
// - sign one scales by one plus m/4096
// - multiplier applied to every conversion result
// - one magnitude step is 1/4096
// - all-zero word gives unity gain
// - host calibrates from zero-gain sensor readings
// - host measures both full-scale codes first
// - host samples result bits on falling clock
// - low frame per word, msb first, 31 bits
// - host makes frame and clock, receive enabled
// - host secondary channel captures second line
// - result lines release when frame ends
package dgc_pkg;
  localparam int RES_BITS = 12;
  localparam int GAIN_BITS = 7;
  localparam int MAG_BITS = 6;
  localparam int SCALE_SHIFT = 12;
  localparam logic [12:0] GAIN_ONE = 13'h1000;
  localparam logic [11:0] FULL_SCALE = 12'hfff;
  localparam logic [6:0] GAIN_RESET = 7'h00;
  // receiver word length code, word is code plus one bits
  localparam logic [4:0] WORD_LEN_CODE = 5'h1e;
  localparam int WORD_BITS = int'(WORD_LEN_CODE) + 1;
  // write header on the command line: write flag, channel, gain word
  localparam int HDR_BITS = 9;
  localparam logic [5:0] HDR_LAST_FALL = 6'h08;
  // link clock made by the host divider
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 128;
  localparam int HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // host register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT_A = 8'h08;
  localparam logic [7:0] ADDR_RESULT_B = 8'h0c;
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_SEC_EN = 1;
  localparam int CTRL_START = 2;
  localparam int CTRL_GAIN_WR = 3;
  localparam int CTRL_GAIN_CH = 4;
  localparam int CTRL_GAIN_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  typedef enum logic [3:0] {
    DGC_IDLE = 4'b0001,
    DGC_LEAD = 4'b0010,
    DGC_LOW = 4'b0100,
    DGC_HIGH = 4'b1000
  } dgc_state_t;
endpackage

// file: dgc_link_if.sv
// interface: serial link between the converter end and the host receiver
`timescale 1ns/1ps
interface dgc_link_if;
  logic serial_clock;
  logic frame_n;
  logic command_line;
  logic result_line_first_out;
  logic result_line_first_oe;
  logic result_line_second_out;
  logic result_line_second_oe;
  wire result_line_first;
  wire result_line_second;
  // undriven lines settle low, as through a pull-down
  assign result_line_first = result_line_first_oe ? result_line_first_out : 1'b0;
  assign result_line_second = result_line_second_oe ? result_line_second_out : 1'b0;
  modport device (
    input serial_clock,
    input frame_n,
    input command_line,
    output result_line_first_out,
    output result_line_first_oe,
    output result_line_second_out,
    output result_line_second_oe
  );
  modport host (
    output serial_clock,
    output frame_n,
    output command_line,
    input result_line_first,
    input result_line_second
  );
endinterface

// file: dgc_device_end.sv
// converter end: gain words, result scaling and serial result output
`timescale 1ns/1ps
module dgc_device_end (
  dgc_link_if.device link,
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [dgc_pkg::RES_BITS-1:0] raw_a,
  input wire logic [dgc_pkg::RES_BITS-1:0] raw_b,
  output logic sample_strobe,
  output logic [dgc_pkg::GAIN_BITS-1:0] gain_a,
  output logic [dgc_pkg::GAIN_BITS-1:0] gain_b
);

  ////////////////////////////////////////////////////////////////////////////
  // scaling

  // factor is 4096 plus or minus the magnitude, so one step is 1/4096
  function automatic logic [dgc_pkg::RES_BITS-1:0] dgc_scale(
    input logic [dgc_pkg::RES_BITS-1:0] raw,
    input logic [dgc_pkg::GAIN_BITS-1:0] g
  );
    logic [12:0] mag;
    logic [12:0] factor;
    logic [24:0] prod;
    mag = {7'h00, g[dgc_pkg::MAG_BITS-1:0]};
    factor = g[dgc_pkg::GAIN_BITS-1] ? dgc_pkg::GAIN_ONE + mag : dgc_pkg::GAIN_ONE - mag;
    prod = {13'h0000, raw} * {12'h000, factor};
    // above full scale only when the factor exceeds one
    if (prod[24])
      dgc_scale = dgc_pkg::FULL_SCALE;
    else
      dgc_scale = prod[23:dgc_pkg::SCALE_SHIFT];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  logic clk_s1;
  logic clk_s2;
  logic clk_d;
  logic frm_s1;
  logic frm_s2;
  logic frm_d;
  logic cmd_s1;
  logic cmd_s2;
  logic clk_fall;
  logic frm_fall;
  logic frm_rise;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_s1 <= 1'b1;
      clk_s2 <= 1'b1;
      clk_d <= 1'b1;
      frm_s1 <= 1'b1;
      frm_s2 <= 1'b1;
      frm_d <= 1'b1;
      cmd_s1 <= 1'b0;
      cmd_s2 <= 1'b0;
    end
    else
    begin
      clk_s1 <= link.serial_clock;
      clk_s2 <= clk_s1;
      clk_d <= clk_s2;
      frm_s1 <= link.frame_n;
      frm_s2 <= frm_s1;
      frm_d <= frm_s2;
      cmd_s1 <= link.command_line;
      cmd_s2 <= cmd_s1;
    end
  end

  assign clk_fall = clk_d & ~clk_s2;
  assign frm_fall = frm_d & ~frm_s2;
  assign frm_rise = ~frm_d & frm_s2;

  ////////////////////////////////////////////////////////////////////////////
  // frame tracking

  logic active;
  logic [5:0] fall_cnt;
  logic [dgc_pkg::HDR_BITS-2:0] hdr;
  logic bit_step;

  // a clock fall in the same cycle as the frame rise is not counted
  assign bit_step = active & clk_fall & ~frm_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active <= 1'b0;
    else if (frm_fall)
      active <= 1'b1;
    else if (frm_rise)
      active <= 1'b0;
  end

  // counter saturates so a long frame never wraps into the header window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fall_cnt <= 6'h00;
    else if (frm_fall)
      fall_cnt <= 6'h00;
    else if (bit_step && fall_cnt != 6'h3f)
      fall_cnt <= fall_cnt + 6'h01;
  end

  // command bits are taken on falling clock edges, first bit first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hdr <= '0;
    else if (bit_step && fall_cnt < dgc_pkg::HDR_LAST_FALL)
      hdr <= {hdr[dgc_pkg::HDR_BITS-3:0], cmd_s2};
  end

  ////////////////////////////////////////////////////////////////////////////
  // gain words, one per channel

  logic [dgc_pkg::GAIN_BITS-1:0] hdr_gain;
  logic hdr_wr;
  logic hdr_ch;

  assign hdr_wr = hdr[7];
  assign hdr_ch = hdr[6];
  assign hdr_gain = {hdr[5:0], cmd_s2};

  // the ninth command bit completes a write; the other channel is untouched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_a <= dgc_pkg::GAIN_RESET;
      gain_b <= dgc_pkg::GAIN_RESET;
    end
    else if (bit_step && fall_cnt == dgc_pkg::HDR_LAST_FALL && hdr_wr)
    begin
      if (hdr_ch)
        gain_b <= hdr_gain;
      else
        gain_a <= hdr_gain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result shifting

  logic [dgc_pkg::WORD_BITS-1:0] shift_a;
  logic [dgc_pkg::WORD_BITS-1:0] shift_b;
  logic [dgc_pkg::WORD_BITS-1:0] word_a;
  logic [dgc_pkg::WORD_BITS-1:0] word_b;

  // result sits in the low bits, zero filled above
  assign word_a = {19'h00000, dgc_scale(raw_a, gain_a)};
  assign word_b = {19'h00000, dgc_scale(raw_b, gain_b)};

  // frame fall samples the core; gain changes apply from the next frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sample_strobe <= 1'b0;
    else
      sample_strobe <= frm_fall;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_a <= '0;
      shift_b <= '0;
    end
    else if (frm_fall)
    begin
      shift_a <= word_a;
      shift_b <= word_b;
    end
    else if (bit_step)
    begin
      shift_a <= {shift_a[dgc_pkg::WORD_BITS-2:0], 1'b0};
      shift_b <= {shift_b[dgc_pkg::WORD_BITS-2:0], 1'b0};
    end
  end

  // the next bit is presented right after each falling edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.result_line_first_out <= 1'b0;
      link.result_line_second_out <= 1'b0;
    end
    else if (frm_fall)
    begin
      link.result_line_first_out <= word_a[dgc_pkg::WORD_BITS-1];
      link.result_line_second_out <= word_b[dgc_pkg::WORD_BITS-1];
    end
    else if (bit_step)
    begin
      link.result_line_first_out <= shift_a[dgc_pkg::WORD_BITS-2];
      link.result_line_second_out <= shift_b[dgc_pkg::WORD_BITS-2];
    end
  end

  // lines are driven only inside the frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.result_line_first_oe <= 1'b0;
      link.result_line_second_oe <= 1'b0;
    end
    else if (frm_rise)
    begin
      link.result_line_first_oe <= 1'b0;
      link.result_line_second_oe <= 1'b0;
    end
    else if (frm_fall)
    begin
      link.result_line_first_oe <= 1'b1;
      link.result_line_second_oe <= 1'b1;
    end
  end

endmodule

// file: dgc_host_end.sv
// host end: serial receiver with secondary channel, controlled over apb
`timescale 1ns/1ps
module dgc_host_end (
  dgc_link_if.host link,
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state on every access

  logic [31:0] ctrl;
  logic start_pend;
  logic done;
  logic busy;
  logic frame_end;
  logic frame_go;
  logic wr_acc;
  logic mapped;
  logic [dgc_pkg::WORD_BITS-1:0] result_a;
  logic [dgc_pkg::WORD_BITS-1:0] result_b;
  dgc_pkg::dgc_state_t state;

  assign wr_acc = psel & penable & pready & pwrite;
  assign mapped = paddr == dgc_pkg::ADDR_CTRL || paddr == dgc_pkg::ADDR_STATUS ||
                  paddr == dgc_pkg::ADDR_RESULT_A || paddr == dgc_pkg::ADDR_RESULT_B;
  assign busy = state != dgc_pkg::DGC_IDLE;

  // ready and read data are both registered, so answer comes one cycle late
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      case (paddr)
        dgc_pkg::ADDR_CTRL: prdata <= ctrl;
        dgc_pkg::ADDR_STATUS: prdata <= {30'h0, done, busy};
        dgc_pkg::ADDR_RESULT_A: prdata <= {1'b0, result_a};
        dgc_pkg::ADDR_RESULT_B: prdata <= {1'b0, result_b};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // start bit never stores; it only raises a pending request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= dgc_pkg::CTRL_RESET;
    else if (wr_acc && paddr == dgc_pkg::ADDR_CTRL)
      ctrl <= pwdata & 32'h0000_7f1b;
  end

  // a new start in the launching cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_pend <= 1'b0;
    else if (wr_acc && paddr == dgc_pkg::ADDR_CTRL && pwdata[dgc_pkg::CTRL_START])
      start_pend <= 1'b1;
    else if (frame_go)
      start_pend <= 1'b0;
  end

  // done is sticky; a frame ending with the clear keeps it set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done <= 1'b0;
    else if (frame_end)
      done <= 1'b1;
    else if (wr_acc && paddr == dgc_pkg::ADDR_STATUS && pwdata[dgc_pkg::STAT_DONE])
      done <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link clock divider and frame sequencer

  logic [3:0] div_cnt;
  logic tick;
  logic [5:0] fall_cnt;
  logic line_a_s1;
  logic line_a_s2;
  logic line_b_s1;
  logic line_b_s2;
  logic [dgc_pkg::WORD_BITS-1:0] rx_a;
  logic [dgc_pkg::WORD_BITS-1:0] rx_b;
  logic [dgc_pkg::HDR_BITS-1:0] cmd_shift;

  assign tick = div_cnt == 4'(dgc_pkg::HALF_CYCLES - 1);
  assign frame_go = state == dgc_pkg::DGC_IDLE && start_pend && ctrl[dgc_pkg::CTRL_RX_EN];
  assign frame_end = state == dgc_pkg::DGC_HIGH && tick && fall_cnt == 6'(dgc_pkg::WORD_BITS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 4'h0;
    else if (state == dgc_pkg::DGC_IDLE || tick)
      div_cnt <= 4'h0;
    else
      div_cnt <= div_cnt + 4'h1;
  end

  // host makes both frame and clock; clock idles high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= dgc_pkg::DGC_IDLE;
      link.frame_n <= 1'b1;
      link.serial_clock <= 1'b1;
      fall_cnt <= 6'h00;
    end
    else
    begin
      case (state)
        dgc_pkg::DGC_IDLE:
          if (frame_go)
          begin
            link.frame_n <= 1'b0;
            fall_cnt <= 6'h00;
            state <= dgc_pkg::DGC_LEAD;
          end
        dgc_pkg::DGC_LEAD, dgc_pkg::DGC_HIGH:
          if (frame_end)
          begin
            link.frame_n <= 1'b1;
            state <= dgc_pkg::DGC_IDLE;
          end
          else if (tick)
          begin
            link.serial_clock <= 1'b0;
            fall_cnt <= fall_cnt + 6'h01;
            state <= dgc_pkg::DGC_LOW;
          end
        dgc_pkg::DGC_LOW:
          if (tick)
          begin
            link.serial_clock <= 1'b1;
            state <= dgc_pkg::DGC_HIGH;
          end
        default:
          state <= dgc_pkg::DGC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive and command shifting

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_a_s1 <= 1'b0;
      line_a_s2 <= 1'b0;
      line_b_s1 <= 1'b0;
      line_b_s2 <= 1'b0;
    end
    else
    begin
      line_a_s1 <= link.result_line_first;
      line_a_s2 <= line_a_s1;
      line_b_s1 <= link.result_line_second;
      line_b_s2 <= line_b_s1;
    end
  end

  // sample in the cycle the clock is driven low, msb first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_a <= '0;
      rx_b <= '0;
    end
    else if (frame_go)
    begin
      rx_a <= '0;
      rx_b <= '0;
    end
    else if (tick && (state == dgc_pkg::DGC_LEAD || state == dgc_pkg::DGC_HIGH) && !frame_end)
    begin
      rx_a <= {rx_a[dgc_pkg::WORD_BITS-2:0], line_a_s2};
      // secondary side stays zero filled when disabled
      if (ctrl[dgc_pkg::CTRL_SEC_EN])
        rx_b <= {rx_b[dgc_pkg::WORD_BITS-2:0], line_b_s2};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_a <= '0;
      result_b <= '0;
    end
    else if (frame_end)
    begin
      result_a <= rx_a;
      result_b <= rx_b;
    end
  end

  // command bits change on rising edges so the converter takes them on falls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_shift <= '0;
      link.command_line <= 1'b0;
    end
    else if (frame_go)
    begin
      cmd_shift <= {ctrl[dgc_pkg::CTRL_GAIN_CH], ctrl[14:8], 1'b0};
      link.command_line <= ctrl[dgc_pkg::CTRL_GAIN_WR];
    end
    else if (state == dgc_pkg::DGC_LOW && tick)
    begin
      cmd_shift <= {cmd_shift[dgc_pkg::HDR_BITS-2:0], 1'b0};
      link.command_line <= cmd_shift[dgc_pkg::HDR_BITS-1];
    end
  end

endmodule

// file: dgc_asserts.sv
// checker: link framing, clock halves and line release
`timescale 1ns/1ps
module dgc_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_clock,
  input wire logic frame_n,
  input wire logic result_line_first_out,
  input wire logic result_line_first_oe,
  input wire logic result_line_second_out,
  input wire logic result_line_second_oe
);
  logic sclk_d;
  logic [5:0] falls;
  logic [9:0] low_len;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // previous clock level for edge finding
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sclk_d <= 1'b1;
    else
      sclk_d <= serial_clock;
  // falls in this frame; cleared while idle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      falls <= 6'h00;
    else if (frame_n)
      falls <= 6'h00;
    else if (sclk_d && !serial_clock)
      falls <= falls + 6'h01;
  // frame length in pclk cycles
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_len <= 10'h000;
    else if (frame_n)
      low_len <= 10'h000;
    else
      low_len <= low_len + 10'h001;
  ////////////////////////////////////////
  sequence s_lead;
    serial_clock [*8] ##1 !serial_clock;
  endsequence
  sequence s_low;
    !serial_clock [*8] ##1 serial_clock;
  endsequence
  sequence s_off;
    !result_line_first_oe && !result_line_second_oe;
  endsequence
  AST_IDLE_CLOCK: assert property (frame_n |-> serial_clock)
    else $error("link clock moved outside a frame");
  AST_LEAD_IN: assert property ($fell(frame_n) |-> s_lead)
    else $error("lead-in before first fall wrong");
  AST_LOW_HALF: assert property ($fell(serial_clock) |-> s_low)
    else $error("low half of link clock wrong");
  AST_HIGH_HALF: assert property ($rose(serial_clock) |-> serial_clock [*8] ##1 (!serial_clock || frame_n))
    else $error("high half of link clock wrong");
  AST_FALL_COUNT: assert property ($rose(frame_n) |-> falls == 6'h1f)
    else $error("frame did not hold 31 falls");
  AST_FRAME_LEN: assert property ($rose(frame_n) |-> low_len == 10'h1f8)
    else $error("frame length wrong");
  AST_DRIVE_ON: assert property ($fell(frame_n) |-> ##[2:6] (result_line_first_oe && result_line_second_oe))
    else $error("result lines not driven in frame");
  AST_RELEASE: assert property ($rose(frame_n) |-> ##[1:5] s_off)
    else $error("result lines not released");
  AST_QUIET: assert property (frame_n && $past(frame_n, 6) |-> s_off)
    else $error("result line driven while idle");
  AST_ZERO_FILL: assert property (!frame_n && falls != 6'h00 && falls < 6'h13
    |-> !result_line_first_out && !result_line_second_out)
    else $error("leading fill bits not zero");
endmodule

// file: dual_channel_gain_correction_test.sv
// testbench: both link ends, apb driven host, gain rows
`timescale 1ns/1ps
module dual_channel_gain_correction_test;
  typedef struct packed {logic [6:0] ga; logic [6:0] gb; logic [11:0] ra; logic [11:0] rb;} dgc_row_t;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] raw_a;
  logic [11:0] raw_b;
  logic [6:0] gain_a;
  logic [6:0] gain_b;
  logic [30:0] wire_a;
  logic [30:0] wire_b;
  logic sclk_d;
  logic [31:0] rd;
  logic err;
  logic sample_strobe;
  logic [6:0] cal;
  int strobes;
  int frames;
  int fail_count;
  int samples_checked;
  int cycles;
  dgc_row_t rows [5];
  dgc_link_if link ();
  dgc_device_end u_dgc_device_end (.link(link), .pclk(pclk), .presetn(presetn), .raw_a(raw_a),
    .raw_b(raw_b), .sample_strobe(sample_strobe), .gain_a(gain_a), .gain_b(gain_b));
  dgc_host_end u_dgc_host_end (.link(link), .pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  dgc_asserts u_dgc_asserts (.pclk(pclk), .presetn(presetn), .serial_clock(link.serial_clock),
    .frame_n(link.frame_n), .result_line_first_out(link.result_line_first_out),
    .result_line_first_oe(link.result_line_first_oe), .result_line_second_out(link.result_line_second_out),
    .result_line_second_oe(link.result_line_second_oe));
  ////////////////////////////////////////
  // clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // own copy of both result lines, taken at link clock falls
  always @(posedge pclk)
  begin
    sclk_d <= link.serial_clock;
    if (sclk_d && !link.serial_clock)
    begin
      wire_a <= {wire_a[29:0], link.result_line_first};
      wire_b <= {wire_b[29:0], link.result_line_second};
    end
  end
  // conversion starts seen; each frame should give exactly one
  always @(posedge pclk)
    if (sample_strobe === 1'b1)
      strobes <= strobes + 1;
  // hang guard, a run needs about 11000 cycles
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  ////////////////////////////////////////
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_gain(input logic [6:0] got, input logic [6:0] exp);
    cmp_word({25'h0000000, got}, {25'h0000000, exp});
  endtask
  // one apb transfer; request held until pready seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // write control, wait for done, clear done
  task run_frame(input logic [31:0] ctrl);
    frames++;
    apb(1'b1, 8'h00, ctrl);
    rd = 32'h0;
    while (rd[1] !== 1'b1)
      apb(1'b0, 8'h04, 32'h0);
    apb(1'b1, 8'h04, 32'h2);
  endtask
  // gain applied, clamped at top of range
  function logic [11:0] scaled(input logic [11:0] raw, input logic [6:0] g);
    logic [24:0] p;
    p = raw * (g[6] ? 13'h1000 + g[5:0] : 13'h1000 - g[5:0]);
    return (p[24:12] > 13'h0fff) ? 12'hfff : p[23:12];
  endfunction
  ////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    raw_a = 12'h000;
    raw_b = 12'h000;
    wire_a = 31'h0;
    wire_b = 31'h0;
    sclk_d = 1'b1;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    strobes = 0;
    frames = 0;
    rows[0] = '{7'h00, 7'h40, 12'h800, 12'h7ff};
    rows[1] = '{7'h3f, 7'h7f, 12'hfff, 12'hfff};
    rows[2] = '{7'h01, 7'h41, 12'h800, 12'h800};
    rows[3] = '{7'h7f, 7'h3f, 12'h100, 12'hfff};
    rows[4] = '{7'h20, 7'h60, 12'h000, 12'habc};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cmp_gain(gain_a, 7'h00);
    cmp_gain(gain_b, 7'h00);
    apb(1'b0, 8'h00, 32'h0);
    cmp_word(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    cmp_word({31'h0, err}, 32'h1);
    // start without receive enable stays pending
    apb(1'b1, 8'h00, 32'h4);
    apb(1'b0, 8'h04, 32'h0);
    cmp_word(rd, 32'h0);
    cmp_word({31'h0, link.frame_n}, 32'h1);
    run_frame(32'h3);
    // rows: gain a, gain b, then a measured frame
    foreach (rows[i])
    begin
      raw_a <= rows[i].ra;
      raw_b <= rows[i].rb;
      run_frame({17'h0, rows[i].ga, 3'h0, 1'b0, 1'b1, 3'h7});
      run_frame({17'h0, rows[i].gb, 3'h0, 1'b1, 1'b1, 3'h7});
      cmp_gain(gain_a, rows[i].ga);
      cmp_gain(gain_b, rows[i].gb);
      run_frame(32'h7);
      apb(1'b0, 8'h08, 32'h0);
      cmp_word(rd, {20'h0, scaled(rows[i].ra, rows[i].ga)});
      apb(1'b0, 8'h0c, 32'h0);
      cmp_word(rd, {20'h0, scaled(rows[i].rb, rows[i].gb)});
      cmp_word({1'b0, wire_a}, {20'h0, scaled(rows[i].ra, rows[i].ga)});
      cmp_word({1'b0, wire_b}, {20'h0, scaled(rows[i].rb, rows[i].gb)});
    end
    // secondary channel off leaves second result empty
    run_frame(32'h5);
    apb(1'b0, 8'h0c, 32'h0);
    cmp_word(rd, 32'h0);
    // calibration: clear gain a, measure top and bottom codes, store derived word
    raw_a <= 12'hfc1;
    raw_b <= 12'h000;
    run_frame({17'h0, 7'h00, 3'h0, 1'b0, 1'b1, 3'h7});
    cmp_gain(gain_a, 7'h00);
    run_frame(32'h7);
    apb(1'b0, 8'h08, 32'h0);
    cmp_word(rd, 32'h0000_0fc1);
    cal = {1'b1, 6'(12'hfff - rd[11:0])};
    apb(1'b0, 8'h0c, 32'h0);
    cmp_word(rd, 32'h0);
    run_frame({17'h0, cal, 3'h0, 1'b0, 1'b1, 3'h7});
    run_frame(32'h7);
    apb(1'b0, 8'h08, 32'h0);
    cmp_word(rd, {20'h0, scaled(12'hfc1, cal)});
    cmp_word(strobes, frames);
    // reset in mid-run clears both gain words
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    cmp_gain(gain_b, 7'h00);
    cmp_gain(gain_a, 7'h00);
    apb(1'b0, 8'h00, 32'h0);
    cmp_word(rd, 32'h0);
    print_verdict();
  end
endmodule
